// ### rtl/fsx_defs.svh
`ifndef FSX_DEFS_SVH
`define FSX_DEFS_SVH

// register indices on the local port
`define FSX_A_CTRL 5'h00
`define FSX_A_IN_BASE 5'h01
`define FSX_A_IN_SIZE 5'h02
`define FSX_A_OUT_BASE 5'h03
`define FSX_A_OUT_SIZE 5'h04
`define FSX_A_STATION 5'h05
`define FSX_A_IO_STATUS 5'h06
`define FSX_A_LINK 5'h07
`define FSX_A_IRQ_STAT 5'h08
`define FSX_A_IRQ_MASK 5'h09
`define FSX_A_CPU_IDX 5'h0a
`define FSX_A_IN_DATA 5'h0b
`define FSX_A_OUT_DATA 5'h0c

// control field positions
`define FSX_B_IN_DIS 0
`define FSX_B_OUT_DIS 1
`define FSX_B_FAST 2

// interrupt bit positions
`define FSX_I_EXCH 0
`define FSX_I_FALL 1
`define FSX_I_PRM 2
`define FSX_I_CFG 3
`define FSX_I_ALLOC 4

// reset values
`define FSX_RST_BASE 16'h0000
`define FSX_RST_IN_SIZE 16'h0001
`define FSX_RST_OUT_SIZE 9'h001
`define FSX_RST_STATION 7'h01

// limits
`define FSX_OUT_MIN 9'h001
`define FSX_OUT_MAX 9'h100
`define FSX_STN_MIN 7'h01
`define FSX_STN_MAX 7'h40
`define FSX_BAUD_MAX 4'h9

// i/o status codes
`define FSX_ST_IDLE 16'h0000
`define FSX_ST_NORMAL 16'h0001
`define FSX_ST_PRM_ERR 16'h0002
`define FSX_ST_CFG_ERR 16'h0004
`define FSX_ST_LOST 16'h0008

// timing
`define FSX_CLK_NS 10
`define FSX_MS_NS 1000000
`define FSX_MS_CYC (`FSX_MS_NS / `FSX_CLK_NS)
`define FSX_STALL_MS 10'd800

`endif

// ### rtl/fsx_pkg.sv
package fsx_pkg;

  typedef enum logic [2:0] {
    await_parameters_state = 3'b001,
    await_config_state = 3'b010,
    cyclic_exchange_state = 3'b100
  } fsx_state_e;

  // parameter frame from the master
  typedef struct packed {
    logic valid;
    logic ok;
    logic [3:0] baud;
    logic [15:0] wd_ms;
  } fsx_prm_s;

  // configuration frame from the master
  typedef struct packed {
    logic valid;
    logic ok;
  } fsx_cfg_s;

  // output data bytes from the master
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } fsx_rx_s;

endpackage

// ### rtl/fsx_mem.sv
`timescale 1ns/1ps

module fsx_mem #(
  parameter int P_W = 16,
  parameter int P_D = 128
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // write side
  input wire logic i_we,
  input wire logic [$clog2(P_D)-1:0] i_waddr,
  input wire logic [P_W-1:0] i_wdata,
  // read side
  input wire logic [$clog2(P_D)-1:0] i_raddr,
  output logic [P_W-1:0] o_rdata
);

  logic [P_W-1:0] mem [P_D];

  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= '0;
    end
    else
    begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

// ### rtl/fsx_top.sv
// Notes on behaviour
// - Separate input and output disable flags stop the CPU exchanging that direction.
// - The input area starts at a set word address, spans a set word count, little-endian.
// - The output area is sized in bytes, only 1 to 256 accepted, little-endian.
// - CPU exchange runs on the fast or reduced-rate scan, unsynchronised to the network.
// - An input register is refused as output and the reverse; only inside set areas.
// - Status code is 0000 idle, 0001 normal, 0002 parameter, 0004 config, 0008 lost.
// - Rates up to 12 Mbps; the rate chosen by the master is adopted and reported.
// - Await parameters, then await configuration, then cyclic exchange.
// - CPU output writes stopping in exchange drop the slave to await parameters 800 ms on.
// - Master silence for the parameter timeout in exchange drops to await parameters.
// - After a fall back, valid initialisation from the master restarts exchange.
// - The station number is kept within 1 to 64.
`timescale 1ns/1ps
`include "fsx_defs.svh"

module fsx_top #(
  parameter int P_MS_CYCLES = `FSX_MS_CYC,
  parameter int P_WORDS = 128
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register port
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // cpu scan ticks
  input wire logic i_scan_fast,
  input wire logic i_scan_slow,
  // master side
  input wire fsx_pkg::fsx_prm_s i_prm,
  input wire fsx_pkg::fsx_cfg_s i_cfg,
  input wire fsx_pkg::fsx_rx_s i_rx,
  input wire logic i_tx_req,
  output logic [7:0] o_tx_byte,
  output logic o_tx_valid,
  // status
  output logic [15:0] o_io_status,
  output logic o_exch,
  output logic o_irq
);
  import fsx_pkg::*;

  localparam int AW = $clog2(P_WORDS);

  if (P_WORDS < 128 || P_MS_CYCLES < 2)
  begin : g_bad_param
    $error("fsx_top: area depth below 128 words or ms divider below 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  fsx_state_e state, next_state;
  logic [15:0] io_status, next_io_status;
  logic in_dis, next_in_dis, out_dis, next_out_dis, fast, next_fast;
  logic [15:0] in_base, next_in_base, in_size, next_in_size;
  logic [15:0] out_base, next_out_base, cpu_idx, next_cpu_idx;
  logic [8:0] out_size, next_out_size;
  logic [6:0] station, next_station;
  logic [3:0] baud, next_baud;
  logic [15:0] wd_ms, next_wd_ms, quiet_ms, next_quiet_ms;
  logic [9:0] stall_ms, next_stall_ms;
  logic out_dirty, next_out_dirty;
  logic [4:0] irq_st, next_irq_st, irq_mask, next_irq_mask, ev;
  logic [AW+1:0] rx_cnt, next_rx_cnt, rx_eff, tx_cnt, next_tx_cnt;
  logic [7:0] rx_lo, next_rx_lo, next_tx_byte;
  logic [15:0] next_rdata;
  logic next_tx_valid;
  logic [31:0] ms_cnt, next_ms_cnt;
  logic ms_tick, scan_tick, in_hit, out_hit, clash, wr_ok;
  logic [15:0] in_off, out_off, out_words;
  logic in_we, alloc_ev;
  logic [15:0] in_wdata, in_q, out_q;

  ////////////////////////////////////////////////////////////////////////////
  // area decode for the cpu word index
  always_comb
  begin
    in_off = cpu_idx - in_base;
    out_off = cpu_idx - out_base;
    out_words = 16'((17'(out_size) + 17'd1) >> 1);
    in_hit = (cpu_idx >= in_base) && (in_off < in_size);
    out_hit = (cpu_idx >= out_base) && (out_off < out_words);
    clash = in_hit && out_hit;
    wr_ok = i_wr && (i_addr == `FSX_A_OUT_DATA) && out_hit && !clash && !out_dis;
    scan_tick = fast ? i_scan_fast : i_scan_slow;
    ms_tick = (ms_cnt == 32'(P_MS_CYCLES - 1));
    next_ms_cnt = ms_tick ? 32'h0 : ms_cnt + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // area buffers
  fsx_mem #(.P_W(16), .P_D(P_WORDS)) u_in_mem (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_we(in_we),
    .i_waddr(rx_eff[AW:1]),
    .i_wdata(in_wdata),
    .i_raddr(in_off[AW-1:0]),
    .o_rdata(in_q)
  );

  fsx_mem #(.P_W(16), .P_D(P_WORDS)) u_out_mem (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_we(wr_ok),
    .i_waddr(out_off[AW-1:0]),
    .i_wdata(i_wdata),
    .i_raddr(tx_cnt[AW:1]),
    .o_rdata(out_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // link state, timers and network data
  always_comb
  begin
    next_state = state;
    next_io_status = io_status;
    next_baud = baud;
    next_wd_ms = wd_ms;
    ev = '0;
    if (i_prm.valid)
    begin
      if (i_prm.ok && i_prm.baud <= `FSX_BAUD_MAX)
      begin
        next_state = await_config_state;
        next_baud = i_prm.baud;
        next_wd_ms = i_prm.wd_ms;
        next_io_status = `FSX_ST_IDLE;
      end
      else
      begin
        next_state = await_parameters_state;
        next_io_status = `FSX_ST_PRM_ERR;
        ev[`FSX_I_PRM] = 1'b1;
      end
    end
    else
    begin
      unique case (state)
        await_parameters_state:
        begin
        end
        await_config_state:
        begin
          if (i_cfg.valid && i_cfg.ok)
          begin
            next_state = cyclic_exchange_state;
            next_io_status = `FSX_ST_NORMAL;
            ev[`FSX_I_EXCH] = 1'b1;
          end
          else if (i_cfg.valid)
          begin
            next_io_status = `FSX_ST_CFG_ERR;
            ev[`FSX_I_CFG] = 1'b1;
          end
        end
        cyclic_exchange_state:
        begin
          if (wd_ms != 16'h0 && quiet_ms >= wd_ms)
          begin
            next_state = await_parameters_state;
            next_io_status = `FSX_ST_LOST;
            ev[`FSX_I_FALL] = 1'b1;
          end
          else if (stall_ms >= `FSX_STALL_MS)
          begin
            next_state = await_parameters_state;
            next_io_status = `FSX_ST_IDLE;
            ev[`FSX_I_FALL] = 1'b1;
          end
        end
      endcase
    end
    // master silence and cpu stall timers
    next_quiet_ms = quiet_ms;
    next_stall_ms = stall_ms;
    if (state != cyclic_exchange_state || (i_rx.valid && i_rx.first))
    begin
      next_quiet_ms = 16'h0;
    end
    else if (ms_tick && quiet_ms != 16'hffff)
    begin
      next_quiet_ms = quiet_ms + 16'h1;
    end
    if (state != cyclic_exchange_state || out_dis || (scan_tick && out_dirty))
    begin
      next_stall_ms = 10'h0;
    end
    else if (ms_tick && stall_ms != 10'h3ff)
    begin
      next_stall_ms = stall_ms + 10'h1;
    end
    next_out_dirty = wr_ok || (out_dirty && !scan_tick);
    // master bytes into the input area, low byte first
    rx_eff = i_rx.first ? '0 : rx_cnt;
    next_rx_cnt = rx_cnt;
    next_rx_lo = rx_lo;
    in_we = 1'b0;
    in_wdata = {i_rx.data, rx_lo};
    if (i_rx.valid && state == cyclic_exchange_state &&
        17'(rx_eff) < {1'b0, in_size[14:0], 1'b0})
    begin
      next_rx_cnt = rx_eff + 1'b1;
      if (rx_eff[0])
      begin
        in_we = 1'b1;
      end
      else
      begin
        next_rx_lo = i_rx.data;
      end
    end
    // output area bytes to the master, low byte first
    next_tx_cnt = (i_rx.valid && i_rx.first) ? '0 : tx_cnt;
    next_tx_valid = 1'b0;
    next_tx_byte = 8'h00;
    if (i_tx_req && state == cyclic_exchange_state && 17'(tx_cnt) < 17'(out_size))
    begin
      next_tx_valid = 1'b1;
      next_tx_byte = tx_cnt[0] ? out_q[15:8] : out_q[7:0];
      next_tx_cnt = tx_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_comb
  begin
    next_in_dis = in_dis;
    next_out_dis = out_dis;
    next_fast = fast;
    next_in_base = in_base;
    next_in_size = in_size;
    next_out_base = out_base;
    next_out_size = out_size;
    next_station = station;
    next_irq_mask = irq_mask;
    next_cpu_idx = cpu_idx;
    next_irq_st = irq_st;
    if (i_wr)
    begin
      unique case (i_addr)
        `FSX_A_CTRL:
        begin
          next_in_dis = i_wdata[`FSX_B_IN_DIS];
          next_out_dis = i_wdata[`FSX_B_OUT_DIS];
          next_fast = i_wdata[`FSX_B_FAST];
        end
        `FSX_A_IN_BASE: next_in_base = i_wdata;
        `FSX_A_IN_SIZE:
        begin
          if (i_wdata != 16'h0 && i_wdata <= 16'(P_WORDS))
          begin
            next_in_size = i_wdata;
          end
        end
        `FSX_A_OUT_BASE: next_out_base = i_wdata;
        `FSX_A_OUT_SIZE:
        begin
          if (i_wdata >= 16'(`FSX_OUT_MIN) && i_wdata <= 16'(`FSX_OUT_MAX))
          begin
            next_out_size = i_wdata[8:0];
          end
        end
        `FSX_A_STATION:
        begin
          if (i_wdata >= 16'(`FSX_STN_MIN) && i_wdata <= 16'(`FSX_STN_MAX))
          begin
            next_station = i_wdata[6:0];
          end
        end
        `FSX_A_IRQ_STAT: next_irq_st = irq_st & ~i_wdata[4:0];
        `FSX_A_IRQ_MASK: next_irq_mask = i_wdata[4:0];
        `FSX_A_CPU_IDX: next_cpu_idx = i_wdata;
        default:
        begin
        end
      endcase
    end
    alloc_ev = (i_wr && i_addr == `FSX_A_OUT_DATA && !out_dis && !wr_ok) ||
      (i_rd && i_addr == `FSX_A_IN_DATA && !in_dis && !(in_hit && !clash));
    // set wins over a clear in the same cycle
    next_irq_st = next_irq_st | ev;
    next_irq_st[`FSX_I_ALLOC] = next_irq_st[`FSX_I_ALLOC] | alloc_ev;
    next_rdata = 16'h0;
    if (i_rd)
    begin
      unique case (i_addr)
        `FSX_A_CTRL: next_rdata = {13'h0, fast, out_dis, in_dis};
        `FSX_A_IN_BASE: next_rdata = in_base;
        `FSX_A_IN_SIZE: next_rdata = in_size;
        `FSX_A_OUT_BASE: next_rdata = out_base;
        `FSX_A_OUT_SIZE: next_rdata = {7'h0, out_size};
        `FSX_A_STATION: next_rdata = {9'h0, station};
        `FSX_A_IO_STATUS: next_rdata = io_status;
        `FSX_A_LINK: next_rdata = {4'h0, baud, 5'h0, state};
        `FSX_A_IRQ_STAT: next_rdata = {11'h0, irq_st};
        `FSX_A_IRQ_MASK: next_rdata = {11'h0, irq_mask};
        `FSX_A_CPU_IDX: next_rdata = cpu_idx;
        `FSX_A_IN_DATA: next_rdata = (in_hit && !clash && !in_dis) ? in_q : 16'h0;
        default: next_rdata = 16'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= await_parameters_state;
      io_status <= `FSX_ST_IDLE;
      in_dis <= 1'b0;
      out_dis <= 1'b0;
      fast <= 1'b0;
      in_base <= `FSX_RST_BASE;
      in_size <= `FSX_RST_IN_SIZE;
      out_base <= `FSX_RST_BASE;
      out_size <= `FSX_RST_OUT_SIZE;
      station <= `FSX_RST_STATION;
      baud <= 4'h0;
      wd_ms <= 16'h0;
      quiet_ms <= 16'h0;
      stall_ms <= 10'h0;
      out_dirty <= 1'b0;
      irq_st <= '0;
      irq_mask <= '0;
      cpu_idx <= 16'h0;
      rx_cnt <= '0;
      rx_lo <= 8'h00;
      tx_cnt <= '0;
      ms_cnt <= 32'h0;
      o_rdata <= 16'h0;
      o_tx_byte <= 8'h00;
      o_tx_valid <= 1'b0;
      o_io_status <= `FSX_ST_IDLE;
      o_exch <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      io_status <= next_io_status;
      in_dis <= next_in_dis;
      out_dis <= next_out_dis;
      fast <= next_fast;
      in_base <= next_in_base;
      in_size <= next_in_size;
      out_base <= next_out_base;
      out_size <= next_out_size;
      station <= next_station;
      baud <= next_baud;
      wd_ms <= next_wd_ms;
      quiet_ms <= next_quiet_ms;
      stall_ms <= next_stall_ms;
      out_dirty <= next_out_dirty;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      cpu_idx <= next_cpu_idx;
      rx_cnt <= next_rx_cnt;
      rx_lo <= next_rx_lo;
      tx_cnt <= next_tx_cnt;
      ms_cnt <= next_ms_cnt;
      o_rdata <= next_rdata;
      o_tx_byte <= next_tx_byte;
      o_tx_valid <= next_tx_valid;
      o_io_status <= next_io_status;
      o_exch <= (next_state == cyclic_exchange_state);
      o_irq <= |(next_irq_st & next_irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_stalled;
    state == cyclic_exchange_state && stall_ms >= `FSX_STALL_MS && !i_prm.valid &&
      !(wd_ms != 16'h0 && quiet_ms >= wd_ms);
  endsequence

  AST_STATUS_CODE: assert property (
    io_status inside {`FSX_ST_IDLE, `FSX_ST_NORMAL, `FSX_ST_PRM_ERR, `FSX_ST_CFG_ERR,
      `FSX_ST_LOST})
    else $error("illegal i/o status code");
  AST_EXCH_ORDER: assert property (
    $rose(state == cyclic_exchange_state) |-> $past(state) == await_config_state &&
      io_status == `FSX_ST_NORMAL)
    else $error("exchange entered out of order");
  AST_CPU_STALL: assert property (
    s_stalled |=> state == await_parameters_state && io_status == `FSX_ST_IDLE)
    else $error("cpu stall did not drop to await parameters");
  AST_MASTER_QUIET: assert property (
    state == cyclic_exchange_state && wd_ms != 16'h0 && quiet_ms >= wd_ms && !i_prm.valid
      |=> state == await_parameters_state && io_status == `FSX_ST_LOST)
    else $error("master silence not handled");
  sequence s_good_prm;
    i_prm.valid && i_prm.ok && i_prm.baud <= `FSX_BAUD_MAX;
  endsequence

  sequence s_good_cfg;
    state == await_config_state && i_cfg.valid && i_cfg.ok && !i_prm.valid;
  endsequence

  AST_REINIT: assert property (
    s_good_prm |=> state == await_config_state && io_status == `FSX_ST_IDLE)
    else $error("no restart after good parameters");
  AST_CFG_ACCEPT: assert property (
    s_good_cfg |=> o_exch && io_status == `FSX_ST_NORMAL)
    else $error("good configuration did not enter exchange");
  AST_OUT_SIZE: assert property (
    out_size >= `FSX_OUT_MIN && out_size <= `FSX_OUT_MAX)
    else $error("output size out of range");
  AST_STATION: assert property (
    station >= `FSX_STN_MIN && station <= `FSX_STN_MAX)
    else $error("station number out of range");
  AST_IN_DISABLED: assert property (
    i_rd && i_addr == `FSX_A_IN_DATA && in_dis |=> o_rdata == 16'h0)
    else $error("input read while disabled");
  AST_ALLOC_REFUSE: assert property (
    i_wr && i_addr == `FSX_A_OUT_DATA && !out_dis && (!out_hit || clash)
      |=> irq_st[`FSX_I_ALLOC] && (!out_dirty || $past(out_dirty)))
    else $error("refused output write not flagged");
  AST_BAUD: assert property (
    baud <= `FSX_BAUD_MAX)
    else $error("unsupported rate adopted");

endmodule

// ### bench/fsx_master_model.sv
`timescale 1ns/1ps

module fsx_master_model (
  // clock
  input wire logic i_clk_sys,
  // frames towards the slave
  output fsx_pkg::fsx_prm_s o_prm,
  output fsx_pkg::fsx_cfg_s o_cfg,
  output fsx_pkg::fsx_rx_s o_rx,
  output logic o_tx_req,
  // answers from the slave
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_valid
);
  import fsx_pkg::*;

  logic [7:0] got_b [4];
  logic got_v [4];

  initial
  begin
    o_prm <= '0;
    o_cfg <= '0;
    o_rx <= '0;
    o_tx_req <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // released fields show the inverse, so stale values never look valid
  task automatic send_prm(input logic ok, input logic [3:0] baud, input logic [15:0] wd);
    fsx_prm_s p;
    p = '{1'b1, ok, baud, wd};
    @(posedge i_clk_sys);
    o_prm <= p;
    @(posedge i_clk_sys);
    o_prm <= ~p;
  endtask

  // only sent after a parameter frame
  task automatic send_cfg(input logic ok);
    fsx_cfg_s c;
    c = '{1'b1, ok};
    @(posedge i_clk_sys);
    o_cfg <= c;
    @(posedge i_clk_sys);
    o_cfg <= ~c;
  endtask

  task automatic send_frame(input logic [31:0] w);
    fsx_rx_s r;
    for (int i = 0; i < 4; i++)
    begin
      r = '{1'b1, i == 0, w[8*i+:8]};
      @(posedge i_clk_sys);
      o_rx <= r;
    end
    @(posedge i_clk_sys);
    o_rx <= ~r;
  endtask

  // requests spaced three cycles apart for the prefetch
  task automatic poll_tx(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clk_sys);
      o_tx_req <= 1'b1;
      @(posedge i_clk_sys);
      o_tx_req <= 1'b0;
      #1;
      got_v[i] = i_tx_valid;
      got_b[i] = i_tx_byte;
      @(posedge i_clk_sys);
    end
  endtask
endmodule

// ### bench/test_fsx_top.sv
`timescale 1ns/1ps
`include "fsx_defs.svh"

module test_fsx_top;
  import fsx_pkg::*;

  logic i_clk_sys = 1'b0;
  logic i_rst_n;
  logic [4:0] i_addr;
  logic [15:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic i_scan_fast;
  logic i_scan_slow;
  fsx_prm_s prm;
  fsx_cfg_s cfg;
  fsx_rx_s rx;
  logic tx_req;
  logic [15:0] o_rdata;
  logic [15:0] o_io_status;
  logic [7:0] o_tx_byte;
  logic o_tx_valid;
  logic o_exch;
  logic o_irq;
  int errors = 0;
  int comparisons = 0;
  int n;

  always #5 i_clk_sys = ~i_clk_sys;

  fsx_top #(.P_MS_CYCLES(10)) uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scan_fast(i_scan_fast),
    .i_scan_slow(i_scan_slow), .i_prm(prm), .i_cfg(cfg), .i_rx(rx), .i_tx_req(tx_req),
    .o_tx_byte(o_tx_byte), .o_tx_valid(o_tx_valid), .o_io_status(o_io_status),
    .o_exch(o_exch), .o_irq(o_irq));

  fsx_master_model m (.i_clk_sys(i_clk_sys), .o_prm(prm), .o_cfg(cfg), .o_rx(rx),
    .o_tx_req(tx_req), .i_tx_byte(o_tx_byte), .i_tx_valid(o_tx_valid));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  // index takes effect two cycles later
  task automatic idx(input logic [15:0] a);
    wr(`FSX_A_CPU_IDX, a);
    @(posedge i_clk_sys);
  endtask

  task automatic tick(input logic fast);
    @(posedge i_clk_sys);
    i_scan_fast <= fast;
    i_scan_slow <= ~fast;
    @(posedge i_clk_sys);
    i_scan_fast <= 1'b0;
    i_scan_slow <= 1'b0;
  endtask

  task automatic outs(input logic [15:0] st, input logic ex);
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk(o_io_status, st);
    chk({15'h0, o_exch}, {15'h0, ex});
  endtask

  task automatic irq(input logic exp);
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk({15'h0, o_irq}, {15'h0, exp});
  endtask

  task automatic init(input logic [3:0] baud, input logic [15:0] wd);
    m.send_prm(1'b1, baud, wd);
    m.send_cfg(1'b1);
    outs(`FSX_ST_NORMAL, 1'b1);
  endtask

  task automatic wait_drop(input int lim);
    n = 0;
    #1;
    while (o_exch !== 1'b0 && n < lim)
    begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (30000) @(posedge i_clk_sys);
    errors++;
    wrap_up();
  end

  initial
  begin
    i_rst_n <= 1'b0;
    i_addr <= '0;
    i_wdata <= '0;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    i_scan_fast <= 1'b0;
    i_scan_slow <= 1'b0;
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    outs(`FSX_ST_IDLE, 1'b0);
    rd(`FSX_A_LINK, 16'h0001);
    rd(`FSX_A_IN_SIZE, `FSX_RST_IN_SIZE);
    rd(5'h1f, 16'h0000);
    // size and station limits
    wr(`FSX_A_OUT_SIZE, 16'h0000);
    wr(`FSX_A_OUT_SIZE, 16'h0101);
    rd(`FSX_A_OUT_SIZE, 16'h0001);
    wr(`FSX_A_OUT_SIZE, 16'h0100);
    rd(`FSX_A_OUT_SIZE, 16'h0100);
    wr(`FSX_A_STATION, 16'h0041);
    wr(`FSX_A_STATION, 16'h0000);
    rd(`FSX_A_STATION, 16'h0001);
    wr(`FSX_A_STATION, 16'h0040);
    rd(`FSX_A_STATION, 16'h0040);
    // bring-up with refusals on the way
    m.send_prm(1'b0, 4'h1, 16'h0000);
    outs(`FSX_ST_PRM_ERR, 1'b0);
    m.send_prm(1'b1, 4'ha, 16'h0000);
    outs(`FSX_ST_PRM_ERR, 1'b0);
    m.send_cfg(1'b1);
    outs(`FSX_ST_PRM_ERR, 1'b0);
    m.send_prm(1'b1, 4'h9, 16'h0000);
    rd(`FSX_A_LINK, 16'h0902);
    m.send_cfg(1'b0);
    outs(`FSX_ST_CFG_ERR, 1'b0);
    m.send_cfg(1'b1);
    outs(`FSX_ST_NORMAL, 1'b1);
    rd(`FSX_A_LINK, 16'h0904);
    rd(`FSX_A_IRQ_STAT, 16'h000d);
    wr(`FSX_A_IRQ_MASK, 16'h0002);
    irq(1'b0);
    wr(`FSX_A_IRQ_MASK, 16'h0001);
    irq(1'b1);
    wr(`FSX_A_IRQ_STAT, 16'h000d);
    irq(1'b0);
    rd(`FSX_A_IRQ_STAT, 16'h0000);
    wr(`FSX_A_IRQ_MASK, 16'h001f);
    // areas, byte order and allocation refusals
    wr(`FSX_A_CTRL, 16'h0004);
    wr(`FSX_A_IN_BASE, 16'h0010);
    wr(`FSX_A_IN_SIZE, 16'h0002);
    wr(`FSX_A_OUT_BASE, 16'h0040);
    wr(`FSX_A_OUT_SIZE, 16'h0003);
    m.send_frame(32'h44332211);
    idx(16'h0010);
    rd(`FSX_A_IN_DATA, 16'h2211);
    idx(16'h0011);
    rd(`FSX_A_IN_DATA, 16'h4433);
    idx(16'h0012);
    rd(`FSX_A_IN_DATA, 16'h0000);
    rd(`FSX_A_IRQ_STAT, 16'h0010);
    wr(`FSX_A_IRQ_STAT, 16'h0010);
    idx(16'h0040);
    wr(`FSX_A_OUT_DATA, 16'hbbaa);
    idx(16'h0041);
    wr(`FSX_A_OUT_DATA, 16'h00cc);
    tick(1'b1);
    idx(16'h0010);
    wr(`FSX_A_OUT_DATA, 16'h1234);
    rd(`FSX_A_IRQ_STAT, 16'h0010);
    wr(`FSX_A_IRQ_STAT, 16'h0010);
    m.send_frame(32'h88776655);
    m.poll_tx(4);
    chk({7'h0, m.got_v[0], m.got_b[0]}, 16'h01aa);
    chk({7'h0, m.got_v[1], m.got_b[1]}, 16'h01bb);
    chk({7'h0, m.got_v[2], m.got_b[2]}, 16'h01cc);
    chk({15'h0, m.got_v[3]}, 16'h0000);
    // output area laid over the input area: writes there are refused
    wr(`FSX_A_OUT_BASE, 16'h0011);
    idx(16'h0011);
    wr(`FSX_A_OUT_DATA, 16'h9999);
    rd(`FSX_A_IRQ_STAT, 16'h0010);
    wr(`FSX_A_IRQ_STAT, 16'h0010);
    wr(`FSX_A_OUT_BASE, 16'h0040);
    // both directions disabled
    wr(`FSX_A_CTRL, 16'h0007);
    rd(`FSX_A_IN_DATA, 16'h0000);
    idx(16'h0040);
    wr(`FSX_A_OUT_DATA, 16'h5555);
    tick(1'b1);
    rd(`FSX_A_IRQ_STAT, 16'h0000);
    wr(`FSX_A_CTRL, 16'h0004);
    m.send_frame(32'h00000000);
    m.poll_tx(1);
    chk({7'h0, m.got_v[0], m.got_b[0]}, 16'h01aa);
    // master silence of 3 ms
    init(4'h3, 16'h0003);
    rd(`FSX_A_LINK, 16'h0304);
    m.send_frame(32'h00000000);
    wait_drop(100);
    chk({15'h0, n >= 15 && n <= 45}, 16'h0001);
    outs(`FSX_ST_LOST, 1'b0);
    // cpu stall after one committed write on the slow scan
    init(4'h9, 16'h0000);
    wr(`FSX_A_CTRL, 16'h0000);
    idx(16'h0040);
    wr(`FSX_A_OUT_DATA, 16'h0102);
    tick(1'b0);
    wait_drop(9000);
    chk({15'h0, n >= 7880 && n <= 8120}, 16'h0001);
    outs(`FSX_ST_IDLE, 1'b0);
    irq(1'b1);
    init(4'h9, 16'h0000);
    wrap_up();
  end
endmodule
